// ===== hdl/reset_and_stop_recovery_ctrl.sv
// Reset and stop-mode recovery sequencer with cause recording.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module reset_and_stop_recovery_ctrl (
  input wire logic ref_clk, // System clock, 20 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [11:0] addr, // Register address.
  input wire logic [7:0] wdata, // Register write data.
  input wire logic wr, // Register write strobe.
  input wire logic rd, // Register read strobe.
  output logic [7:0] rdata, // Read data, cycle after rd.
  input wire logic wdt_osc, // Watchdog RC oscillator, async.
  input wire logic supply_low, // Supply below power-on level, async.
  input wire logic brownout_detector, // Brown-out detect, async.
  input wire logic ext_reset_n, // External reset pin, async.
  input wire logic debug_pin, // Debug pin, async.
  input wire logic [7:0] wake_pins, // Wake-up pins, async.
  input wire logic [7:0] wake_en, // Wake-up enables per pin.
  input wire logic stop_mode, // Core is in stop mode.
  input wire logic wdt_timeout, // Watchdog time-out pulse.
  input wire logic dbg_rst_req, // Debugger reset request bit.
  output logic dbg_rst_clr, // Pulse: clear debugger request.
  output logic core_reset, // Core held in reset.
  output logic periph_reset, // Control registers to reset values.
  output logic gpio_force_input, // All GPIO pins to input.
  output logic sys_clk_en, // System clock running.
  output logic vec_fetch, // Pulse: fetch reset vector.
  output logic [15:0] vec_hi_addr, // Vector high byte address.
  output logic [15:0] vec_lo_addr, // Vector low byte address.
  output logic wdt_irq // Pulse: watchdog interrupt after wake.
);

  // Two-stage synchronisers for everything off the clock domain.
  logic [12:0] async_in;
  logic [12:0] sync1_ff;
  logic [12:0] sync2_ff;
  logic osc_prev_ff;
  logic [7:0] wake_prev_ff;

  assign async_in = {wake_pins, debug_pin, ext_reset_n,
                     brownout_detector, supply_low, wdt_osc};

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync1_ff <= rst_ctrl_pkg::SYNC_IDLE;
      sync2_ff <= rst_ctrl_pkg::SYNC_IDLE;
      osc_prev_ff <= 1'b0;
      wake_prev_ff <= 8'h00;
    end else if (ce) begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      osc_prev_ff <= sync2_ff[0];
      wake_prev_ff <= sync2_ff[12:5];
    end
  end

  logic osc_s;
  logic supply_s;
  logic bo_s;
  logic ext_n_s;
  logic dbg_pin_s;
  logic [7:0] wake_s;
  logic osc_tick;

  assign osc_s = sync2_ff[0];
  assign supply_s = sync2_ff[1];
  assign bo_s = sync2_ff[2];
  assign ext_n_s = sync2_ff[3];
  assign dbg_pin_s = sync2_ff[4];
  assign wake_s = sync2_ff[12:5];
  assign osc_tick = osc_s & ~osc_prev_ff;

  // Wake-up change detection, one lane per pin.
  logic [7:0] wake_chg;
  genvar gi;
  generate
    for (gi = 0; gi < rst_ctrl_pkg::WAKE_W; gi++) begin : g_wake
      assign wake_chg[gi] = wake_en[gi] &
        (wake_s[gi] ^ wake_prev_ff[gi]);
    end
  endgenerate

  // Registers, state and counters.
  rst_ctrl_pkg::rst_state_t state_ff;
  rst_ctrl_pkg::rst_state_t nxt_state;
  logic [6:0] osc_cnt_ff;
  logic [6:0] nxt_osc_cnt;
  logic [4:0] clk_cnt_ff;
  logic [4:0] nxt_clk_cnt;
  logic [2:0] ext_cnt_ff;
  logic [2:0] nxt_ext_cnt;
  logic sys_type_ff;
  logic nxt_sys_type;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic [1:0] opt_ff;
  logic [1:0] nxt_opt;
  logic irq_pend_ff;
  logic nxt_irq_pend;
  logic fetch_ff;
  logic nxt_fetch;
  logic dbg_clr_ff;
  logic nxt_dbg_clr;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic timeout_reset_option;
  logic bo_stop_opt;
  logic sup_evt;
  logic ext_ok;
  logic wdt_sys;
  logic sys_evt;
  logic rec_evt;
  logic [7:0] sys_cause;
  logic [7:0] rec_cause;

  assign timeout_reset_option = opt_ff[rst_ctrl_pkg::OPT_TO_RESET_BIT];
  assign bo_stop_opt = opt_ff[rst_ctrl_pkg::OPT_BO_STOP_BIT];

  // Supply events win over all others; a brown-out counts in stop mode only when bo_stop_opt is set.
  assign sup_evt = supply_s |
    (bo_s & (~stop_mode | bo_stop_opt));
  assign ext_ok = (ext_cnt_ff == rst_ctrl_pkg::EXT_MIN);
  assign wdt_sys = wdt_timeout & timeout_reset_option;

  // Source classification by operating mode.
  always_comb begin
    sys_evt = 1'b0;
    rec_evt = 1'b0;
    sys_cause = 8'h00;
    rec_cause = 8'h00;
    rec_cause[rst_ctrl_pkg::STOP_BIT] = 1'b1;
    if (stop_mode) begin
      sys_evt = ext_ok | ~dbg_pin_s;
      rec_evt = wdt_timeout | (|wake_chg);
      rec_cause[rst_ctrl_pkg::DOG_CAUSE_BIT] = wdt_timeout;
    end else begin
      sys_evt = ext_ok | wdt_sys | dbg_rst_req;
    end
    if (ext_ok) begin
      sys_cause[rst_ctrl_pkg::PIN_CAUSE_BIT] = 1'b1;
    end else if (!stop_mode && wdt_sys) begin
      sys_cause[rst_ctrl_pkg::DOG_CAUSE_BIT] = 1'b1;
    end else if (!stop_mode) begin
      sys_cause[rst_ctrl_pkg::POR_BIT] = 1'b1;
    end
  end

  // Sequencer, cause register, options and read port.
  always_comb begin
    nxt_state = state_ff;
    nxt_osc_cnt = osc_cnt_ff;
    nxt_clk_cnt = clk_cnt_ff;
    nxt_sys_type = sys_type_ff;
    nxt_stat = stat_ff;
    nxt_opt = opt_ff;
    nxt_irq_pend = irq_pend_ff;
    nxt_fetch = 1'b0;
    nxt_dbg_clr = 1'b0;
    nxt_irq = 1'b0;
    nxt_rdata = 8'h00;
    nxt_ext_cnt = ext_cnt_ff;
    if (ext_n_s) begin
      nxt_ext_cnt = 3'h0;
    end else if (!ext_ok) begin
      nxt_ext_cnt = ext_cnt_ff + 3'h1;
    end
    if (rd) begin
      if (addr == rst_ctrl_pkg::STATUS_ADDR) begin
        nxt_rdata = stat_ff;
      end else if (addr == rst_ctrl_pkg::OPTCTL_ADDR) begin
        nxt_rdata[rst_ctrl_pkg::OPT_TO_RESET_BIT] =
          opt_ff[rst_ctrl_pkg::OPT_TO_RESET_BIT];
        nxt_rdata[rst_ctrl_pkg::OPT_BO_STOP_BIT] =
          opt_ff[rst_ctrl_pkg::OPT_BO_STOP_BIT];
      end
    end
    // Software clears cause flags by writing ones; hardware sets win.
    if (wr) begin
      if (addr == rst_ctrl_pkg::STATUS_ADDR) begin
        nxt_stat = stat_ff & ~(wdata & rst_ctrl_pkg::CAUSE_MASK);
      end else if (addr == rst_ctrl_pkg::OPTCTL_ADDR) begin
        nxt_opt[rst_ctrl_pkg::OPT_TO_RESET_BIT] =
          wdata[rst_ctrl_pkg::OPT_TO_RESET_BIT];
        nxt_opt[rst_ctrl_pkg::OPT_BO_STOP_BIT] =
          wdata[rst_ctrl_pkg::OPT_BO_STOP_BIT];
      end
    end
    case (state_ff)
      rst_ctrl_pkg::ST_RUN: begin
        if (sys_evt) begin
          nxt_state = rst_ctrl_pkg::ST_OSC;
          nxt_osc_cnt = 7'h00;
          nxt_sys_type = 1'b1;
          nxt_stat = sys_cause;
          nxt_dbg_clr = dbg_rst_req & ~stop_mode;
        end else if (rec_evt) begin
          nxt_state = rst_ctrl_pkg::ST_OSC;
          nxt_osc_cnt = 7'h00;
          nxt_sys_type = 1'b0;
          nxt_stat = rec_cause;
          nxt_irq_pend = wdt_timeout & ~timeout_reset_option;
        end
      end
      rst_ctrl_pkg::ST_OSC: begin
        if (osc_tick) begin
          if (osc_cnt_ff == rst_ctrl_pkg::OSC_LAST) begin
            nxt_state = rst_ctrl_pkg::ST_CLK;
            nxt_clk_cnt = 5'h00;
          end else begin
            nxt_osc_cnt = osc_cnt_ff + 7'h01;
          end
        end
      end
      rst_ctrl_pkg::ST_CLK: begin
        if (clk_cnt_ff == rst_ctrl_pkg::CLK_LAST) begin
          if (!ext_n_s) begin
            nxt_state = rst_ctrl_pkg::ST_HOLD;
          end else begin
            nxt_state = rst_ctrl_pkg::ST_RUN;
            nxt_fetch = 1'b1;
          end
        end else begin
          nxt_clk_cnt = clk_cnt_ff + 5'h01;
        end
      end
      rst_ctrl_pkg::ST_HOLD: begin
        if (ext_n_s) begin
          nxt_state = rst_ctrl_pkg::ST_RUN;
          nxt_fetch = 1'b1;
        end
      end
      default: begin
        nxt_state = rst_ctrl_pkg::ST_OSC;
      end
    endcase
    if (nxt_fetch && irq_pend_ff) begin
      nxt_irq = 1'b1;
      nxt_irq_pend = 1'b0;
    end
    // Supply low, or a brown-out outside stop mode or with bo_stop_opt set, restarts a full power-on sequence.
    if (sup_evt) begin
      nxt_state = rst_ctrl_pkg::ST_OSC;
      nxt_osc_cnt = 7'h00;
      nxt_sys_type = 1'b1;
      nxt_stat = rst_ctrl_pkg::STAT_RESET;
      nxt_irq_pend = 1'b0;
      nxt_fetch = 1'b0;
      nxt_irq = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= rst_ctrl_pkg::ST_OSC;
      osc_cnt_ff <= 7'h00;
      clk_cnt_ff <= 5'h00;
      ext_cnt_ff <= 3'h0;
      sys_type_ff <= 1'b1;
      stat_ff <= rst_ctrl_pkg::STAT_RESET;
      opt_ff <= rst_ctrl_pkg::OPT_RESET;
      irq_pend_ff <= 1'b0;
      fetch_ff <= 1'b0;
      dbg_clr_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      osc_cnt_ff <= nxt_osc_cnt;
      clk_cnt_ff <= nxt_clk_cnt;
      ext_cnt_ff <= nxt_ext_cnt;
      sys_type_ff <= nxt_sys_type;
      stat_ff <= nxt_stat;
      opt_ff <= nxt_opt;
      irq_pend_ff <= nxt_irq_pend;
      fetch_ff <= nxt_fetch;
      dbg_clr_ff <= nxt_dbg_clr;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs come straight from the state and pulse registers.
  logic in_reset;
  assign in_reset = (state_ff != rst_ctrl_pkg::ST_RUN);
  assign core_reset = in_reset;
  assign periph_reset = in_reset & sys_type_ff;
  assign gpio_force_input = in_reset & sys_type_ff;
  assign sys_clk_en = (state_ff != rst_ctrl_pkg::ST_OSC);
  assign vec_fetch = fetch_ff;
  assign vec_hi_addr = rst_ctrl_pkg::VEC_HI_ADDR;
  assign vec_lo_addr = rst_ctrl_pkg::VEC_LO_ADDR;
  assign dbg_rst_clr = dbg_clr_ff;
  assign wdt_irq = irq_ff;
  assign rdata = rdata_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sup_restart_a: assert property (
    ce && sup_evt |=> state_ff == rst_ctrl_pkg::ST_OSC && sys_type_ff
      && stat_ff == rst_ctrl_pkg::STAT_RESET)
    else $error("supply event did not restart a system reset");

  osc_done_a: assert property (
    ce && osc_tick && !sup_evt && state_ff == rst_ctrl_pkg::ST_OSC
      && osc_cnt_ff == rst_ctrl_pkg::OSC_LAST
      |=> state_ff == rst_ctrl_pkg::ST_CLK && clk_cnt_ff == 5'h00)
    else $error("oscillator count did not hand over to clock count");

  clk_done_a: assert property (
    ce && !sup_evt && state_ff == rst_ctrl_pkg::ST_CLK
      && clk_cnt_ff == rst_ctrl_pkg::CLK_LAST
      |=> state_ff != rst_ctrl_pkg::ST_CLK)
    else $error("clock count overran");

  clk_idle_a: assert property (
    $rose(sys_clk_en) |-> $past(osc_cnt_ff) == rst_ctrl_pkg::OSC_LAST
      && core_reset)
    else $error("system clock started before oscillator count ended");

  ext_hold_a: assert property (
    ce && !sup_evt && state_ff == rst_ctrl_pkg::ST_HOLD && !ext_n_s
      |=> core_reset)
    else $error("left reset while reset pin low");

  ext_cause_a: assert property (
    ce && !sup_evt && state_ff == rst_ctrl_pkg::ST_RUN && ext_ok
      |=> stat_ff[rst_ctrl_pkg::PIN_CAUSE_BIT] && sys_type_ff)
    else $error("external cause flag not set");

  stop_wdt_a: assert property (
    ce && !sup_evt && state_ff == rst_ctrl_pkg::ST_RUN && stop_mode
      && !ext_ok && dbg_pin_s && wdt_timeout
      |=> stat_ff[rst_ctrl_pkg::DOG_CAUSE_BIT]
      && stat_ff[rst_ctrl_pkg::STOP_BIT]
      && !sys_type_ff)
    else $error("stop timeout flags wrong");

  wake_rec_a: assert property (
    ce && !sup_evt && state_ff == rst_ctrl_pkg::ST_RUN && stop_mode
      && !ext_ok && dbg_pin_s && (|wake_chg)
      |=> core_reset && !periph_reset)
    else $error("wake change did not start stop recovery");

  fetch_once_a: assert property (
    ce && vec_fetch |-> !core_reset ##1 !vec_fetch)
    else $error("vector fetch not a single pulse after reset");

endmodule : reset_and_stop_recovery_ctrl

// ===== hdl/rst_ctrl_pkg.sv
// Constants for the reset and stop-recovery controller.
package rst_ctrl_pkg;

  // Register map on the 12-bit register port.
  localparam logic [11:0] STATUS_ADDR = 12'hFF0;
  localparam logic [11:0] OPTCTL_ADDR = 12'hFF4;

  // Cause flags held in the watchdog control register.
  localparam int POR_BIT = 7;
  localparam int STOP_BIT = 6;
  localparam int DOG_CAUSE_BIT = 5;
  localparam int PIN_CAUSE_BIT = 4;
  localparam logic [7:0] CAUSE_MASK = 8'hF0;
  localparam logic [7:0] STAT_RESET = 8'h80;

  // Option register fields and reset value.
  localparam int OPT_TO_RESET_BIT = 0;
  localparam int OPT_BO_STOP_BIT = 1;
  localparam logic [1:0] OPT_RESET = 2'h3;

  // Reset latency: watchdog oscillator ticks, then system clocks.
  localparam int OSC_TICKS = 66;
  localparam int CLK_CYCLES = 16;
  localparam logic [6:0] OSC_LAST = 7'(OSC_TICKS - 1);
  localparam logic [4:0] CLK_LAST = 5'(CLK_CYCLES - 1);

  // Least low time of the external reset pin, in system clocks.
  localparam logic [2:0] EXT_MIN = 3'h4;

  // Reset vector location in program memory.
  localparam logic [15:0] VEC_HI_ADDR = 16'h0002;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0003;

  localparam int WAKE_W = 8;

  // Synchroniser reset value: the reset pin and the debug pin rest high.
  localparam logic [12:0] SYNC_IDLE = 13'h0018;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_OSC = 4'b0010,
    ST_CLK = 4'b0100,
    ST_HOLD = 4'b1000
  } rst_state_t;

endpackage : rst_ctrl_pkg

// ===== sim/core_model.sv
// Behavioural model of the processor core beside the reset controller.
`timescale 1ns/10ps
module core_model (
  input wire logic ref_clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic core_reset, // Core held in reset.
  input wire logic dbg_rst_clr, // Clear of the debugger request.
  input wire logic vec_fetch, // Vector fetch pulse.
  input wire logic wdt_irq, // Watchdog interrupt pulse.
  input wire logic want_stop, // Bench asks the core to stop.
  input wire logic want_dbg, // Bench asks for a debugger reset.
  output logic stop_mode, // Core is stopped.
  output logic dbg_rst_req, // Debugger reset request bit.
  output int fetches, // Vector fetches seen.
  output int irqs // Interrupts taken.
);
  // A core put back into reset always comes out of stop mode.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stop_mode <= 1'b0;
      dbg_rst_req <= 1'b0;
      fetches <= 0;
      irqs <= 0;
    end else begin
      if (core_reset) begin
        stop_mode <= 1'b0;
      end else if (want_stop) begin
        stop_mode <= 1'b1;
      end
      if (dbg_rst_clr) begin
        dbg_rst_req <= 1'b0;
      end else if (want_dbg) begin
        dbg_rst_req <= 1'b1;
      end
      if (vec_fetch) begin
        fetches <= fetches + 1;
      end
      if (wdt_irq) begin
        irqs <= irqs + 1;
      end
    end
  end
endmodule : core_model

// ===== sim/testbench.sv
// Self-checking testbench for the reset and stop-recovery controller.
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0, resetn = 1'b0, wdt_osc = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata, wake_pins = 8'h00;
  logic wr = 1'b0, rd = 1'b0, supply_low = 1'b0, brownout_detector = 1'b0;
  logic ext_reset_n = 1'b1, debug_pin = 1'b1, wdt_timeout = 1'b0;
  logic want_stop = 1'b0, want_dbg = 1'b0, stop_mode, dbg_rst_req;
  logic ce = 1'b1;
  logic dbg_rst_clr, core_reset, periph_reset, gpio_force_input;
  logic sys_clk_en, vec_fetch, wdt_irq;
  logic [15:0] vec_hi_addr, vec_lo_addr;
  int fetches, irqs, err_total = 0, num_checks = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  always #100 wdt_osc = ~wdt_osc;
  reset_and_stop_recovery_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wdt_osc(wdt_osc), .supply_low(supply_low),
    .brownout_detector(brownout_detector), .ext_reset_n(ext_reset_n),
    .debug_pin(debug_pin), .wake_pins(wake_pins), .wake_en(8'h01),
    .stop_mode(stop_mode), .wdt_timeout(wdt_timeout),
    .dbg_rst_req(dbg_rst_req), .dbg_rst_clr(dbg_rst_clr),
    .core_reset(core_reset), .periph_reset(periph_reset),
    .gpio_force_input(gpio_force_input), .sys_clk_en(sys_clk_en),
    .vec_fetch(vec_fetch), .vec_hi_addr(vec_hi_addr),
    .vec_lo_addr(vec_lo_addr), .wdt_irq(wdt_irq));
  core_model core (.ref_clk(ref_clk), .resetn(resetn),
    .core_reset(core_reset), .dbg_rst_clr(dbg_rst_clr),
    .vec_fetch(vec_fetch), .wdt_irq(wdt_irq), .want_stop(want_stop),
    .want_dbg(want_dbg), .stop_mode(stop_mode), .dbg_rst_req(dbg_rst_req),
    .fetches(fetches), .irqs(irqs));
  task results();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(e));
  endtask : rd_chk
  task ticks(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : ticks
  task dog();
    @(posedge ref_clk);
    wdt_timeout <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
  endtask : dog
  task enter_stop();
    @(posedge ref_clk);
    want_stop <= 1'b1;
    @(posedge ref_clk);
    want_stop <= 1'b0;
    ticks(2);
  endtask : enter_stop
  // Waits for a sequence to start and checks the reset kind.
  task go(input logic p);
    int k;
    k = 0;
    while (core_reset !== 1'b1 && k < 20) begin
      ticks(1);
      k++;
    end
    chk(16'(core_reset), 16'h0001);
    chk(16'(sys_clk_en), 16'h0000);
    chk(16'(periph_reset), 16'(p));
    chk(16'(gpio_force_input), 16'(p));
  endtask : go
  // Waits for the release and counts system clocks spent in reset.
  task done(input logic c16);
    int k;
    int n;
    k = 0;
    n = 0;
    while (core_reset === 1'b1 && k < 2000) begin
      ticks(1);
      k++;
      if (sys_clk_en === 1'b1 && core_reset === 1'b1) n++;
    end
    chk(16'(vec_fetch), 16'h0001);
    if (c16) chk(16'(n), 16'h0010);
  endtask : done
  task t_boot();
    rd_chk(12'hFF0, 8'h80);
    rd_chk(12'hFF4, 8'h03);
    rd_chk(12'hFF1, 8'h00);
    go(1'b1);
    done(1'b1);
    rd_chk(12'hFF0, 8'h80);
    chk(vec_hi_addr, 16'h0002);
    chk(vec_lo_addr, 16'h0003);
  endtask : t_boot
  task t_dog();
    dog();
    go(1'b1);
    done(1'b1);
    rd_chk(12'hFF0, 8'h20);
    wr_reg(12'hFF0, 8'hF0);
    rd_chk(12'hFF0, 8'h00);
    wr_reg(12'hFF4, 8'h00);
    dog();
    ticks(30);
    chk(16'(core_reset), 16'h0000);
  endtask : t_dog
  task t_stop_dog();
    enter_stop();
    dog();
    go(1'b0);
    done(1'b1);
    rd_chk(12'hFF0, 8'h60);
    chk(16'(irqs), 16'h0001);
  endtask : t_stop_dog
  task t_brown_stop();
    wr_reg(12'hFF4, 8'h01);
    enter_stop();
    @(posedge ref_clk);
    brownout_detector <= 1'b1;
    ticks(20);
    chk(16'(core_reset), 16'h0000);
    @(posedge ref_clk);
    brownout_detector <= 1'b0;
  endtask : t_brown_stop
  // The first change on enabled pin 0 arrives while the clock enable freezes the block.
  task t_wake();
    @(posedge ref_clk);
    wake_pins <= 8'h02;
    ticks(20);
    chk(16'(core_reset), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      if (i > 0) enter_stop();
      @(posedge ref_clk);
      ce <= (i != 0);
      wake_pins[0] <= ~wake_pins[0];
      ticks(10);
      chk(16'(core_reset), 16'(i != 0));
      @(posedge ref_clk);
      ce <= 1'b1;
      go(1'b0);
      done(1'b1);
      rd_chk(12'hFF0, 8'h40);
    end
  endtask : t_wake
  // The pin is first sampled low on three edges only, which is too short.
  task t_ext();
    @(posedge ref_clk);
    ext_reset_n <= 1'b0;
    ticks(2);
    @(posedge ref_clk);
    ext_reset_n <= 1'b1;
    ticks(20);
    chk(16'(core_reset), 16'h0000);
    @(posedge ref_clk);
    ext_reset_n <= 1'b0;
    go(1'b1);
    ticks(400);
    chk(16'(core_reset), 16'h0001);
    @(posedge ref_clk);
    ext_reset_n <= 1'b1;
    done(1'b0);
    rd_chk(12'hFF0, 8'h10);
  endtask : t_ext
  task t_debug();
    @(posedge ref_clk);
    want_dbg <= 1'b1;
    @(posedge ref_clk);
    want_dbg <= 1'b0;
    go(1'b1);
    done(1'b1);
    chk(16'(dbg_rst_req), 16'h0000);
    rd_chk(12'hFF0, 8'h80);
    enter_stop();
    @(posedge ref_clk);
    debug_pin <= 1'b0;
    go(1'b1);
    @(posedge ref_clk);
    debug_pin <= 1'b1;
    done(1'b1);
    rd_chk(12'hFF0, 8'h00);
  endtask : t_debug
  task t_supply();
    wr_reg(12'hFF4, 8'h03);
    dog();
    go(1'b1);
    ticks(100);
    @(posedge ref_clk);
    supply_low <= 1'b1;
    ticks(10);
    chk(16'(core_reset), 16'h0001);
    @(posedge ref_clk);
    supply_low <= 1'b0;
    done(1'b1);
    rd_chk(12'hFF0, 8'h80);
  endtask : t_supply
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_boot();
    t_dog();
    t_stop_dog();
    t_brown_stop();
    t_wake();
    t_ext();
    t_debug();
    t_supply();
    results();
  end
endmodule : testbench
